// [logic/i2c_port_pkg.sv]
// Constants and carrier types for the two-wire slave register port.
// Assumes a single 25 MHz system clock samples the bus lines.
package i2c_port_pkg;
    localparam logic [7:0] SLAVE_ADDR_BASE = 8'h90;
    localparam int STRAP_UPPER_WEIGHT = 8;
    localparam int STRAP_LOWER_WEIGHT = 2;
    localparam logic [1:0] STRAP_VDD = 2'h0;
    localparam logic [1:0] STRAP_VSS = 2'h1;
    localparam logic [1:0] STRAP_SCL = 2'h2;
    localparam logic [1:0] STRAP_SDA = 2'h3;
    localparam int REG_SEL_MSB = 6;
    localparam int REG_SEL_LSB = 3;
    localparam int CHAN_MSB = 2;
    localparam int CHAN_LSB = 1;
    localparam logic [1:0] CHAN_FIRST = 2'h0;
    localparam logic [1:0] CHAN_SECOND = 2'h1;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    localparam logic [7:0] READ_ZERO = 8'h00;

    typedef struct packed {
        logic [3:0] reg_sel;
        logic [1:0] chan;
    } reg_addr_t;

    typedef struct packed {
        logic wr;
        logic rd;
        reg_addr_t addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_t;
endpackage : i2c_port_pkg

// [logic/bus_line_sync.sv]
// Two-flop synchroniser plus edge detection for one bus line.
// Assumes the line is asynchronous to ref_clk_i; idles high.
`timescale 1ns/1ns
module bus_line_sync
    import i2c_port_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic line_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else if (ce_i) begin
            meta_ff <= line_i;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level_o = sync_ff;
    assign rise_o = sync_ff & ~prev_ff;
    assign fall_o = ~sync_ff & prev_ff;
endmodule : bus_line_sync

// [logic/i2c_slave_register_port.sv]
// Two-wire slave port giving an outside master access to the UART registers.
// Assumes the register side answers a read in the same cycle (rdata_i is combinational on addr).
//
// Contract
// R1: Data falling while clock high is a start.
// R2: Data rising while clock high is a stop; transaction ends.
// R3: Only the master makes start and stop conditions.
// R4: Data line stays stable while clock high.
// R5: Bytes are eight bits, MSB first, then one acknowledge slot.
// R6: Master clocks the ack; transmitter releases, acknowledger pulls low.
// R7: Acknowledge every accepted address, register-address and data byte.
// R8: Leave data released (NACK) when a further byte cannot be accepted.
// R9: Master reading acknowledges all but the last byte.
// R10: Master should stop after a timeout without acknowledge.
// R11: First byte: seven address bits, then direction bit (1 = read).
// R12: Match seven bits after start; acknowledge and take direction.
// R13: Address is 0x90 + 8*upper strap + 2*lower strap.
// R14: Register-address byte follows the slave address and is acknowledged.
// R15: Write cycle writes each data byte to the named location.
// R16: Read cycle: repeated start, read address, shift data until NACK.
// R17: Repeated start begins a new address phase.
// R18: No limit on bytes between start and stop.
// R19: Bits 6:3 register, bits 2:1 channel, bits 7 and 0 ignored.
// R20: On mismatch stay released and ignore bytes until next start.
// R21: Reserved channel: no register change, no pop, reads return zero.
`timescale 1ns/1ns
module i2c_slave_register_port
    import i2c_port_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [1:0] addr_strap_upper_i,
    input wire logic [1:0] addr_strap_lower_i,
    output reg_req_t req_o,
    input wire logic [7:0] rdata_i,
    output logic busy_o
);
    typedef enum {
        ST_IDLE,
        ST_DEV_ADDR,
        ST_DEV_ACK,
        ST_REG_ADDR,
        ST_REG_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK,
        ST_IGNORE
    } port_state_t;

    // States in which the master shifts a byte into the port
    function automatic logic rx_state(input port_state_t s);
        return (s == ST_DEV_ADDR) || (s == ST_REG_ADDR) || (s == ST_WR_DATA);
    endfunction : rx_state

    // States whose ninth slot the port may pull low
    function automatic logic ack_state(input port_state_t s);
        return (s == ST_DEV_ACK) || (s == ST_REG_ACK) || (s == ST_WR_ACK);
    endfunction : ack_state

    ////////////////////////////////////////////////////////////////////////
    // Line sampling

    // Edges seen here lag the pins by one to two clocks
    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;

    bus_line_sync u_scl_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .line_i(scl_i),
        .level_o(scl_lvl),
        .rise_o(scl_rise),
        .fall_o(scl_fall)
    );

    bus_line_sync u_sda_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .line_i(sda_i),
        .level_o(sda_lvl),
        .rise_o(sda_rise),
        .fall_o(sda_fall)
    );

    // SDA edge while SCL high is a condition, never a data bit
    logic start_det;
    logic stop_det;
    assign start_det = sda_fall & scl_lvl; // R1 R4 R17
    assign stop_det = sda_rise & scl_lvl; // R2 R4

    ////////////////////////////////////////////////////////////////////////
    // Address straps

    function automatic logic [7:0] strap_address(input logic [1:0] upper, input logic [1:0] lower);
        logic [7:0] sum;
        sum = SLAVE_ADDR_BASE;
        sum = sum + 8'(int'(upper) * STRAP_UPPER_WEIGHT);
        sum = sum + 8'(int'(lower) * STRAP_LOWER_WEIGHT);
        return sum;
    endfunction : strap_address

    function automatic logic chan_ok(input logic [1:0] chan);
        return (chan == CHAN_FIRST) || (chan == CHAN_SECOND);
    endfunction : chan_ok

    // Straps are static pins; latch them synchronised, not at reset
    logic [3:0] strap_meta_ff;
    logic [3:0] strap_sync_ff;
    logic [6:0] own_addr_ff;
    // Full 8-bit form; bit 0 is the direction slot and is dropped
    logic [7:0] strap_addr;
    assign strap_addr = strap_address(strap_sync_ff[3:2], strap_sync_ff[1:0]); // R13

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_meta_ff <= 4'h0;
            strap_sync_ff <= 4'h0;
            own_addr_ff <= SLAVE_ADDR_BASE[7:1];
        end else if (ce_i) begin
            strap_meta_ff <= {addr_strap_upper_i, addr_strap_lower_i};
            strap_sync_ff <= strap_meta_ff;
            own_addr_ff <= strap_addr[7:1]; // R13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte shifter and state

    port_state_t state_ff;
    logic [7:0] shift_ff;
    logic [2:0] bit_cnt_ff;
    reg_addr_t addr_ff;
    logic byte_done;

    assign byte_done = scl_rise && (bit_cnt_ff == BIT_CNT_LAST);

    // Bits are sampled on SCL rise, MSB first
    // A stray rise before a stop or repeated start is undone by the count reset
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_ff <= 8'h00;
            bit_cnt_ff <= 3'h0;
        end else if (ce_i) begin
            if (start_det || stop_det) begin
                bit_cnt_ff <= 3'h0;
            end else if (scl_rise && rx_state(state_ff)) begin
                shift_ff <= {shift_ff[6:0], sda_lvl}; // R5
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end else if (scl_rise && state_ff == ST_RD_DATA) begin
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
        end
    end

    logic [7:0] rx_byte;
    assign rx_byte = {shift_ff[6:0], sda_lvl};

    logic ack_pending_ff;
    logic master_nack_ff;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            ack_pending_ff <= 1'b0;
            master_nack_ff <= 1'b0;
            addr_ff <= '0;
        end else if (ce_i) begin
            if (start_det) begin
                state_ff <= ST_DEV_ADDR; // R17
                ack_pending_ff <= 1'b0;
                master_nack_ff <= 1'b0;
            end else if (stop_det) begin
                state_ff <= ST_IDLE; // R2
                ack_pending_ff <= 1'b0;
            end else begin
                unique case (state_ff)
                    ST_IDLE, ST_IGNORE: begin
                        state_ff <= state_ff; // R20
                    end
                    ST_DEV_ADDR: begin
                        if (byte_done) begin
                            if (rx_byte[7:1] == own_addr_ff) begin // R11 R12
                                ack_pending_ff <= 1'b1;
                                master_nack_ff <= rx_byte[0];
                                state_ff <= ST_DEV_ACK;
                            end else begin
                                state_ff <= ST_IGNORE; // R20
                            end
                        end
                    end
                    ST_DEV_ACK: begin
                        // Leave the ack slot on the falling edge after its pulse
                        if (scl_fall && !ack_pending_ff) begin
                            state_ff <= master_nack_ff ? ST_RD_DATA : ST_REG_ADDR;
                        end else if (scl_fall) begin
                            ack_pending_ff <= 1'b0;
                        end
                    end
                    ST_REG_ADDR: begin
                        if (byte_done) begin
                            addr_ff.reg_sel <= rx_byte[REG_SEL_MSB:REG_SEL_LSB]; // R14 R19
                            addr_ff.chan <= rx_byte[CHAN_MSB:CHAN_LSB]; // R19
                            ack_pending_ff <= 1'b1;
                            state_ff <= ST_REG_ACK;
                        end
                    end
                    ST_REG_ACK: begin
                        if (scl_fall && !ack_pending_ff) begin
                            state_ff <= ST_WR_DATA;
                        end else if (scl_fall) begin
                            ack_pending_ff <= 1'b0;
                        end
                    end
                    ST_WR_DATA: begin
                        if (byte_done) begin
                            ack_pending_ff <= 1'b1;
                            state_ff <= ST_WR_ACK; // R18
                        end
                    end
                    ST_WR_ACK: begin
                        if (scl_fall && !ack_pending_ff) begin
                            state_ff <= ST_WR_DATA;
                        end else if (scl_fall) begin
                            ack_pending_ff <= 1'b0;
                        end
                    end
                    ST_RD_DATA: begin
                        if (byte_done) begin
                            ack_pending_ff <= 1'b1;
                            state_ff <= ST_RD_ACK;
                        end
                    end
                    ST_RD_ACK: begin
                        // Master NACK ends the read; only a start revives us
                        // First fall closes the eighth bit; the next rise is the slot
                        if (scl_fall && ack_pending_ff) begin
                            ack_pending_ff <= 1'b0;
                        end else if (scl_rise) begin
                            master_nack_ff <= sda_lvl; // R9
                        end else if (scl_fall) begin
                            state_ff <= master_nack_ff ? ST_IGNORE : ST_RD_DATA; // R16
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register requests

    reg_req_t req_ff;
    logic [7:0] tx_ff;

    // Load the outgoing byte at the fall that opens each read byte
    logic rd_load;
    assign rd_load = scl_fall && ((state_ff == ST_DEV_ACK && !ack_pending_ff && master_nack_ff)
                     || (state_ff == ST_RD_ACK && !ack_pending_ff && !master_nack_ff));

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_ff <= '0;
            tx_ff <= 8'h00;
        end else if (ce_i) begin
            req_ff.wr <= 1'b0;
            req_ff.rd <= 1'b0;
            // Address leads every strobe, so rdata_i has settled by rd_load
            req_ff.addr <= addr_ff;
            if (state_ff == ST_WR_DATA && byte_done && !start_det && !stop_det) begin
                req_ff.wr <= chan_ok(addr_ff.chan); // R15 R21
                req_ff.wdata <= rx_byte;
            end else if (rd_load) begin
                req_ff.rd <= chan_ok(addr_ff.chan); // R21
                tx_ff <= chan_ok(addr_ff.chan) ? rdata_i : READ_ZERO; // R16 R21
            end else if (state_ff == ST_RD_DATA && scl_fall) begin
                tx_ff <= {tx_ff[6:0], 1'b0}; // R5
            end
        end
    end

    assign req_o = req_ff;

    ////////////////////////////////////////////////////////////////////////
    // Data line drive

    pin_drive_t drive_ff;
    logic in_ack;
    assign in_ack = ack_state(state_ff);

    // Changes on SCL fall, so SDA holds through each high phase; a start or stop releases it at once
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            drive_ff <= '{o: 1'b1, oe: 1'b0};
        end else if (ce_i) begin
            if (start_det || stop_det) begin
                drive_ff <= '{o: 1'b1, oe: 1'b0};
            end else if (scl_fall) begin
                if (in_ack && ack_pending_ff) begin
                    drive_ff <= '{o: 1'b0, oe: 1'b1}; // R6 R7 R8
                end else if (rd_load) begin
                    // Reserved channel reads shift out zeros, a pulled-low line
                    drive_ff <= '{o: 1'b0, oe: !(chan_ok(addr_ff.chan) ? rdata_i[7] : READ_ZERO[7])};
                end else if (state_ff == ST_RD_DATA && bit_cnt_ff != 3'h0) begin
                    drive_ff <= '{o: 1'b0, oe: !tx_ff[6]}; // R4 R5
                end else begin
                    drive_ff <= '{o: 1'b1, oe: 1'b0}; // R6 R20
                end
            end
        end
    end

    // Open drain: a one is a released line
    assign sda_o = drive_ff.o;
    assign sda_oe_o = drive_ff.oe;

    // Status only; a master that never stops leaves it set
    logic busy_ff;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_ff <= 1'b0;
        end else if (ce_i) begin
            if (start_det) begin
                busy_ff <= 1'b1; // R3
            end else if (stop_det) begin
                busy_ff <= 1'b0;
            end
        end
    end
    assign busy_o = busy_ff;
endmodule : i2c_slave_register_port

// [dv/i2c_port_properties.sv]
// Checker for the two-wire slave register port, bound to its top module.
// Assumes one clock domain and ce_i held high while frames run.
`timescale 1ns/1ns
module i2c_port_properties
    import i2c_port_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic [1:0] addr_strap_upper_i,
    input wire logic [1:0] addr_strap_lower_i,
    input wire reg_req_t req_o,
    input wire logic [7:0] rdata_i,
    input wire logic busy_o
);
    default clocking dc @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    property p_low_drive; sda_oe_o |-> !sda_o; endproperty
    // Past guard keeps ack edges near a clock rise from looking like conditions
    property p_start_busy; ce_i && scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:5] busy_o; endproperty
    property p_stop_idle; ce_i && scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:5] !busy_o; endproperty
    property p_hold_high; scl_i [*3] |-> $stable(sda_oe_o); endproperty
    property p_wr_pulse; req_o.wr |=> !req_o.wr && !req_o.rd; endproperty
    property p_wr_ack; req_o.wr |-> ##[1:8] sda_oe_o; endproperty
    property p_reserved; req_o.wr || req_o.rd |-> !req_o.addr.chan[1]; endproperty
    property p_req_frame; req_o.wr || req_o.rd |-> busy_o; endproperty
    property p_idle_released; !busy_o |-> !sda_oe_o; endproperty
    a_low_drive: assert property (p_low_drive) else $error("data driven high");
    a_start_busy: assert property (p_start_busy) else $error("start not seen");
    a_stop_idle: assert property (p_stop_idle) else $error("stop not seen");
    a_hold_high: assert property (p_hold_high) else $error("data moved in clock high");
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
    a_wr_ack: assert property (p_wr_ack) else $error("written byte not acked");
    a_reserved: assert property (p_reserved) else $error("reserved channel access");
    a_req_frame: assert property (p_req_frame) else $error("access outside frame");
    a_idle_released: assert property (p_idle_released) else $error("drive outside frame");
    c_write: cover property (req_o.wr);
    c_read: cover property (req_o.rd);
    c_stop: cover property ($fell(busy_o));
endmodule : i2c_port_properties

bind i2c_slave_register_port i2c_port_properties u_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_strap_upper_i(addr_strap_upper_i),
    .addr_strap_lower_i(addr_strap_lower_i), .req_o(req_o), .rdata_i(rdata_i), .busy_o(busy_o));

// [dv/i2c_master_model.sv]
// Behavioural bus master for the two-wire port: clock line and open-drain data.
// Assumes pull-ups on both lines; the clock stands still between frames.
`timescale 1ns/1ns
module i2c_master_model (
    input wire logic ref_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick
    ////////////////////////////////////////////////////////////////
    task automatic start();
        tick(1);
        sda_low_o = 1'b0;
        tick(3);
        scl_o = 1'b1;
        tick(4);
        sda_low_o = 1'b1;
        tick(4);
        scl_o = 1'b0;
    endtask : start
    task automatic stop();
        tick(1);
        sda_low_o = 1'b1;
        tick(3);
        scl_o = 1'b1;
        tick(4);
        sda_low_o = 1'b0;
        tick(4);
    endtask : stop
    // One cycle after the clock fall before data moves, so no false condition
    task automatic bit_xfer(input logic b, output logic r);
        tick(1);
        sda_low_o = !b;
        tick(3);
        scl_o = 1'b1;
        tick(2);
        r = sda_i;
        tick(2);
        scl_o = 1'b0;
    endtask : bit_xfer
    // Ack slot clocked here; ack_bit high releases the line
    task automatic byte_xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q,
        output logic ackr);
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], q[i]);
        bit_xfer(ack_bit, ackr);
    endtask : byte_xfer
endmodule : i2c_master_model

// [dv/i2c_slave_register_port_test.sv]
// Self-checking bench for the two-wire slave register port.
// Assumes the master model drives the bus and a function stands for the registers.
`timescale 1ns/1ns
module i2c_slave_register_port_test;
    import i2c_port_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] up = 2'h0;
    logic [1:0] lo = 2'h0;
    logic scl, sda_low, sda_o, sda_oe_o, busy_o, sda;
    reg_req_t req;
    logic [7:0] rdata;
    logic [31:0] seed = 32'h0000AFEC;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_rd = 0;
    reg_req_t wq[$];
    always #20 ref_clk_i = !ref_clk_i;
    assign sda = !(sda_low || (sda_oe_o && !sda_o));
    assign rdata = {req.addr, 2'h0} ^ 8'h3C;
    i2c_slave_register_port u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_strap_upper_i(up), .addr_strap_lower_i(lo), .req_o(req),
        .rdata_i(rdata), .busy_o(busy_o));
    i2c_master_model u_mst (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    always @(posedge ref_clk_i) begin
        if (req.wr)
            wq.push_back(req);
        if (req.rd)
            n_rd++;
    end
    ////////////////////////////////////////////////////////////////
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    function automatic logic [7:0] exp_read(input logic [7:0] ra);
        return ra[2] ? 8'h00 : {ra[6:1], 2'h0} ^ 8'h3C;
    endfunction : exp_read
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] a, ra, q, d[3];
        logic k;
        int n;
        repeat (4) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        for (int s = 0; s < 16; s++) begin
            {up, lo} = s[3:0];
            repeat (4) @(posedge ref_clk_i);
            a = 8'h90 + {3'h0, up, 3'h0} + {5'h0, lo, 1'h0};
            ra = rnd();
            n = 1 + rnd() % 3;
            u_mst.start();
            u_mst.byte_xfer(a, 1'b1, q, k);
            check({7'h0, k}, 8'h00);
            check({7'h0, busy_o}, 8'h01);
            u_mst.byte_xfer(ra, 1'b1, q, k);
            check({7'h0, k}, 8'h00);
            for (int i = 0; i < n; i++) begin
                d[i] = rnd();
                u_mst.byte_xfer(d[i], 1'b1, q, k);
                check({7'h0, k}, 8'h00);
            end
            u_mst.stop();
            check({7'h0, busy_o}, 8'h00);
            check(8'(wq.size()), ra[2] ? 8'h00 : 8'(n));
            while (wq.size() > 0) begin
                check({2'h0, wq[0].addr}, {2'h0, ra[6:1]});
                check(wq[0].wdata, d[n - wq.size()]);
                void'(wq.pop_front());
            end
            // Read a fresh location so the port cannot lean on the last write
            ra = rnd();
            // Another strap setting's address must be ignored whole
            u_mst.start();
            u_mst.byte_xfer(a ^ 8'h02, 1'b1, q, k);
            check({7'h0, k}, 8'h01);
            u_mst.byte_xfer(rnd(), 1'b1, q, k);
            check({7'h0, k}, 8'h01);
            u_mst.stop();
            n_rd = 0;
            u_mst.start();
            u_mst.byte_xfer(a, 1'b1, q, k);
            u_mst.byte_xfer(ra, 1'b1, q, k);
            u_mst.start();
            u_mst.byte_xfer(a | 8'h01, 1'b1, q, k);
            check({7'h0, k}, 8'h00);
            u_mst.byte_xfer(8'hFF, 1'b0, q, k);
            check(q, exp_read(ra));
            u_mst.byte_xfer(8'hFF, 1'b1, q, k);
            check(q, exp_read(ra));
            u_mst.stop();
            check(8'(n_rd), ra[2] ? 8'h00 : 8'h02);
        end
        test_done();
    end
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        n_mismatch++;
        test_done();
    end
endmodule : i2c_slave_register_port_test
